// ---- rtl/pp_pin_drv.sv ----
// Single port 3 output driver: push/pull or open-drain
`timescale 1ns/1ps
module pp_pin_drv
(
    input  wire logic drive_in,                               // Direction: 1 = output
    input  wire logic od_in,                                  // 1 = open-drain driver
    input  wire logic data_in,                                // Level to put on the pin
    output logic      pin_out,                                // Pin output level
    output logic      pin_oe_n_out                            // Low while driving
);
    import pp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Driver: an input pin floats; open-drain only pulls low
    always_comb
    begin
        if (!drive_in)
        begin
            pin_out      = 1'b0;                              // Driver off
            pin_oe_n_out = 1'b1;
        end
        else if (od_in)
        begin
            pin_out      = 1'b0;
            pin_oe_n_out = data_in;
        end
        else
        begin
            pin_out      = data_in;                           // Push/pull
            pin_oe_n_out = 1'b0;
        end
    end
endmodule

// ---- rtl/pp_pkg.sv ----
// Constants shared by the port 3 / port 5 pin logic
package pp_pkg;
    // Port widths
    localparam int unsigned P3_W          = 16;               // Port 3 bit positions
    localparam int unsigned P5_W          = 6;                // Port 5 usable bits
    localparam int unsigned P5_LSB        = 10;               // Port 5 lowest bit number
    localparam int unsigned P3_MISSING    = 14;               // Absent port 3 position
    // Port 3 alternate function bit positions
    localparam int unsigned P3_TMR_B_TGL  = 1;                // Timer unit b toggle out
    localparam int unsigned P3_CAPTURE    = 2;                // Capture trigger in
    localparam int unsigned P3_TMR_A_TGL  = 3;                // Timer unit a toggle out
    localparam int unsigned P3_A_CORE_UD  = 4;                // Timer a core up/down in
    localparam int unsigned P3_A_AUX2     = 5;                // Timer a aux2 in
    localparam int unsigned P3_A_CORE_CNT = 6;                // Timer a core count/gate
    localparam int unsigned P3_A_AUX1     = 7;                // Timer a aux1 in
    localparam int unsigned P3_SSC_SYNC_SERIAL_MASTER_RX_SLAVE_TX   = 8;                // Master rx / slave tx
    localparam int unsigned P3_SSC_SYNC_SERIAL_MASTER_TX_SLAVE_RX   = 9;                // Master tx / slave rx
    localparam int unsigned P3_ASC_TX     = 10;               // Async serial tx / clock
    localparam int unsigned P3_ASC_RX     = 11;               // Async serial rx / sync data
    localparam int unsigned P3_HIGH_BYTE  = 12;               // High byte enable / strobe
    localparam int unsigned P3_SSC_CLK    = 13;               // Serial clock
    localparam int unsigned P3_CLK_OUT    = 15;               // System clock out
    // Port 5 bit positions, relative to P5_LSB
    localparam int unsigned P5_B_CORE_UD  = 0;                // Timer b core up/down
    localparam int unsigned P5_B_AUX_UD   = 1;                // Timer b aux up/down
    localparam int unsigned P5_B_CORE_CNT = 2;                // Timer b core count
    localparam int unsigned P5_B_AUX_CNT  = 3;                // Timer b aux count
    localparam int unsigned P5_A_AUX2_UD  = 4;                // Timer a aux2 up/down
    localparam int unsigned P5_A_AUX1_UD  = 5;                // Timer a aux1 up/down
    // Reset values and masks
    localparam logic [15:0] P3_VALID      = 16'hbfff;         // Implemented port 3 bits
    localparam logic [15:0] P3_DIR_RST    = 16'h0000;         // All bits input
    localparam logic [15:0] P3_OD_RST     = 16'h0000;         // Push/pull
    localparam logic [15:0] P3_DATA_RST   = 16'h0000;         // Output latch cleared
    localparam logic [5:0]  P5_RST        = 6'h00;            // Port 5 sample reset
endpackage

// ---- rtl/pp_port_logic.sv ----
// Port 3 bidirectional and port 5 input-only pin logic with alternate functions
`timescale 1ns/1ps
module pp_port_logic
(
    input  wire logic        mclk_in,                         // CPU clock, 20 MHz
    input  wire logic        rst_n_in,                        // Sync reset, active low
    // Software control of port 3
    input  wire logic [15:0] p3_dir_in,                       // Direction, 1 = output
    input  wire logic [15:0] p3_od_in,                        // 1 = open-drain
    input  wire logic [15:0] p3_data_in,                      // Output latch value
    input  wire logic        alt_timer_tgl_en_in,             // Toggle latches on 1, 3
    input  wire logic        alt_ssc_en_in,                   // Sync serial on 8, 9, 13
    input  wire logic        ssc_master_in,                   // Sync serial master mode
    input  wire logic        alt_asc_en_in,                   // Async serial on 10, 11
    input  wire logic        asc_sync_mode_in,                // Async channel sync mode
    input  wire logic        alt_high_byte_en_in,             // High byte signal on 12
    input  wire logic        high_byte_sel_in,                // 0 = enable, 1 = strobe
    input  wire logic        clk_out_en_in,                   // System clock on 15
    // Peripheral outputs to pins
    input  wire logic        timer_b_toggle_in,               // Timer unit b toggle latch
    input  wire logic        timer_a_toggle_in,               // Timer unit a toggle latch
    input  wire logic        ssc_tx_in,                       // Sync serial transmit data
    input  wire logic        ssc_clk_in,                      // Sync serial master clock
    input  wire logic        async_serial_tx_in,              // Async tx data or clock
    input  wire logic        asc_sync_data_in,                // Async sync-mode data out
    input  wire logic        high_byte_enable_in,             // Bus high byte enable
    input  wire logic        high_byte_write_strobe_in,       // Bus high byte strobe
    // Pins
    input  wire logic [15:0] p3_pin_in,                       // Port 3 pin levels
    output logic      [15:0] p3_pin_out,                      // Port 3 drive levels
    output logic      [15:0] p3_pin_oe_n_out,                 // Low while driving
    input  wire logic [15:10] p5_pin_in,                      // Port 5 pin levels
    // Port reads
    output logic      [15:0] p3_read_out,                     // Sampled port 3
    output logic      [15:10] p5_read_out,                    // Sampled port 5
    // Pin inputs to peripherals
    output logic             timer_b_core_updown_out,         // Timer b core up/down
    output logic             timer_b_aux_updown_out,          // Timer b aux up/down
    output logic             timer_b_core_count_out,          // Timer b core count
    output logic             timer_b_aux_count_out,           // Timer b aux count
    output logic             timer_a_aux2_updown_out,         // Timer a aux2 up/down
    output logic             timer_a_aux1_updown_out,         // Timer a aux1 up/down
    output logic             capture_trigger_out,             // Capture register trigger
    output logic             timer_a_core_updown_out,         // Timer a core up/down
    output logic             timer_a_aux2_count_out,          // Timer a aux2 input
    output logic             timer_a_core_count_gate_out,     // Timer a core count/gate
    output logic             timer_a_aux1_count_out,          // Timer a aux1 input
    output logic             ssc_rx_out,                      // Sync serial receive data
    output logic             ssc_clk_rx_out,                  // Sync serial slave clock
    output logic             async_serial_rx_out              // Async serial rx data
);
    import pp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [15:0] dir_q;                                       // Direction latch
    logic [15:0] od_q;                                        // Driver type latch
    logic [15:0] out_q;                                       // Output latch after muxing
    logic [15:0] next_out;                                    // Next output latch
    logic        clk_sel_q;                                   // Clock output selected
    logic [15:0] p3_in_q;                                     // Port 3 sample
    logic [5:0]  p5_in_q;                                     // Port 5 sample
    logic [15:0] drive_data;                                  // Level given to drivers

    ////////////////////////////////////////////////////////////////////////////////
    // Direction and driver type latches; all pins start as inputs
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            dir_q <= P3_DIR_RST;
            od_q  <= P3_OD_RST;                               // Push/pull after reset
        end
        else
        begin
            dir_q <= p3_dir_in & P3_VALID;
            od_q  <= p3_od_in & P3_VALID;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Output value: latch data or alternate function per bit
    always_comb
    begin
        next_out = p3_data_in;
        if (alt_timer_tgl_en_in)
        begin
            next_out[P3_TMR_B_TGL] = timer_b_toggle_in;
            next_out[P3_TMR_A_TGL] = timer_a_toggle_in;
        end
        if (alt_ssc_en_in)
        begin
            if (ssc_master_in)
            begin
                next_out[P3_SSC_SYNC_SERIAL_MASTER_TX_SLAVE_RX] = ssc_tx_in;
                next_out[P3_SSC_CLK]  = ssc_clk_in;
            end
            else
            begin
                next_out[P3_SSC_SYNC_SERIAL_MASTER_RX_SLAVE_TX] = ssc_tx_in;
            end
        end
        if (alt_asc_en_in)
        begin
            next_out[P3_ASC_TX] = async_serial_tx_in;
            if (asc_sync_mode_in)
            begin
                next_out[P3_ASC_RX] = asc_sync_data_in;
            end
        end
        if (alt_high_byte_en_in)
        begin
            next_out[P3_HIGH_BYTE] = high_byte_sel_in ? high_byte_write_strobe_in
                                                      : high_byte_enable_in;
        end
        next_out = next_out & P3_VALID;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Output latch and clock output select
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            out_q     <= P3_DATA_RST;                         // Latch cleared
            clk_sel_q <= 1'b0;                                // Clock output off
        end
        else
        begin
            out_q     <= next_out;                            // Registered pin data
            clk_sel_q <= clk_out_en_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Driver data; bit 15 passes the CPU clock itself when selected
    always_comb
    begin
        drive_data             = out_q;
        drive_data[P3_CLK_OUT] = clk_sel_q ? mclk_in : out_q[P3_CLK_OUT];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin drivers; the absent position never drives
    generate
        for (genvar i = 0; i < P3_W; i++)
        begin : g_pin
            if (i == P3_MISSING)
            begin : g_absent
                assign p3_pin_out[i]      = 1'b0;
                assign p3_pin_oe_n_out[i] = 1'b1;
            end
            else
            begin : g_drv
                pp_pin_drv u_drv
                (
                    .drive_in     (dir_q[i]),
                    .od_in        (od_q[i]),
                    .data_in      (drive_data[i]),
                    .pin_out      (p3_pin_out[i]),
                    .pin_oe_n_out (p3_pin_oe_n_out[i])
                );
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Input sampling of both ports
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            p3_in_q <= P3_DATA_RST;                           // Sample cleared
            p5_in_q <= P5_RST;                                // Sample cleared
        end
        else
        begin
            p3_in_q <= p3_pin_in & P3_VALID;
            p5_in_q <= p5_pin_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Port read values
    assign p3_read_out = p3_in_q;                             // Absent bit reads zero
    assign p5_read_out = p5_in_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Port 5 pins to the timer units
    assign timer_b_core_updown_out = p5_in_q[P5_B_CORE_UD];
    assign timer_b_aux_updown_out  = p5_in_q[P5_B_AUX_UD];
    assign timer_b_core_count_out  = p5_in_q[P5_B_CORE_CNT];
    assign timer_b_aux_count_out   = p5_in_q[P5_B_AUX_CNT];
    assign timer_a_aux2_updown_out = p5_in_q[P5_A_AUX2_UD];
    assign timer_a_aux1_updown_out = p5_in_q[P5_A_AUX1_UD];

    ////////////////////////////////////////////////////////////////////////////////
    // Port 3 pins to the timers
    assign capture_trigger_out         = p3_in_q[P3_CAPTURE];
    assign timer_a_core_updown_out     = p3_in_q[P3_A_CORE_UD];
    assign timer_a_aux2_count_out      = p3_in_q[P3_A_AUX2];
    assign timer_a_core_count_gate_out = p3_in_q[P3_A_CORE_CNT];
    assign timer_a_aux1_count_out      = p3_in_q[P3_A_AUX1];

    ////////////////////////////////////////////////////////////////////////////////
    // Port 3 pins to the serial channels; receive pin follows master/slave role
    assign ssc_rx_out          = ssc_master_in ? p3_in_q[P3_SSC_SYNC_SERIAL_MASTER_RX_SLAVE_TX]
                                               : p3_in_q[P3_SSC_SYNC_SERIAL_MASTER_TX_SLAVE_RX];
    assign ssc_clk_rx_out      = p3_in_q[P3_SSC_CLK];
    assign async_serial_rx_out = p3_in_q[P3_ASC_RX];
endmodule

// ---- sim/pp_board_model.sv ----
// Board side of port 3: external drivers resolved against the chip's pin drivers
`timescale 1ns/1ps
module pp_board_model
(
    input  wire logic [15:0] drive_level_in,   // Chip drive levels
    input  wire logic [15:0] drive_oe_n_in,    // Chip drive enables, low = driving
    input  wire logic [15:0] ext_level_in,     // Board pattern, new every cycle
    output logic      [15:0] pin_level_out     // Resolved pin level
);
    ////////////////////////////////////////////////////////////////////////////////
    // A released pin shows the changing board pattern, never the chip's last value
    assign pin_level_out = (drive_oe_n_in & ext_level_in) | (~drive_oe_n_in & drive_level_in);
endmodule

// ---- sim/pp_port_logic_bench.sv ----
// Randomised self-checking bench for the port 3 / port 5 pin logic
`timescale 1ns/1ps
module pp_port_logic_bench;
    import pp_pkg::*;
    logic        mclk_in = 1'b0;           // CPU clock
    logic        rst_n_in = 1'b0;          // Sync reset
    logic [15:0] dir = '0, od = '0, dat = '0, ext = '0; // Port 3 stimulus
    logic [8:0]  ctl = '0;                 // Alternate enables and selects
    logic [7:0]  pd = '0;                  // Peripheral output data
    logic [15:10] p5 = '0;                 // Port 5 pin levels
    logic [15:0] pin_o, oe_n, pin, rd, e_oe, e_out, e_rd, m_pin, msk, eff;
    logic [15:10] p5_rd, e_p5;
    logic [13:0] per, e_per;               // Sampled peripheral inputs
    logic        ck_drv;                   // Clock seen on bit 15 this cycle
    logic        ck_od;                    // Bit 15 clock goes out open-drain
    integer      seed = 98782, num_errors = 0, comparisons = 0, i, b;
    ////////////////////////////////////////////////////////////////////////////////
    // Clock and watchdog
    initial forever #25 mclk_in = ~mclk_in;
    initial
    begin
        #(2000 * 50);
        num_errors++;
        close_out;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Design and board
    pp_port_logic DUT (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .p3_dir_in(dir), .p3_od_in(od),
        .p3_data_in(dat), .alt_timer_tgl_en_in(ctl[0]), .alt_ssc_en_in(ctl[1]),
        .ssc_master_in(ctl[2]), .alt_asc_en_in(ctl[3]), .asc_sync_mode_in(ctl[4]),
        .alt_high_byte_en_in(ctl[5]), .high_byte_sel_in(ctl[6]), .clk_out_en_in(ctl[7]),
        .timer_b_toggle_in(pd[0]), .timer_a_toggle_in(pd[1]), .ssc_tx_in(pd[2]),
        .ssc_clk_in(pd[3]), .async_serial_tx_in(pd[4]), .asc_sync_data_in(pd[5]),
        .high_byte_enable_in(pd[6]), .high_byte_write_strobe_in(pd[7]), .p3_pin_in(pin),
        .p3_pin_out(pin_o), .p3_pin_oe_n_out(oe_n), .p5_pin_in(p5), .p3_read_out(rd),
        .p5_read_out(p5_rd), .timer_b_core_updown_out(per[0]), .timer_b_aux_updown_out(per[1]),
        .timer_b_core_count_out(per[2]), .timer_b_aux_count_out(per[3]),
        .timer_a_aux2_updown_out(per[4]), .timer_a_aux1_updown_out(per[5]),
        .capture_trigger_out(per[6]), .timer_a_core_updown_out(per[7]),
        .timer_a_aux2_count_out(per[8]), .timer_a_core_count_gate_out(per[9]),
        .timer_a_aux1_count_out(per[10]), .ssc_rx_out(per[11]), .ssc_clk_rx_out(per[12]),
        .async_serial_rx_out(per[13]));
    pp_board_model u_board (.drive_level_in(pin_o), .drive_oe_n_in(oe_n), .ext_level_in(ext),
        .pin_level_out(pin));
    ////////////////////////////////////////////////////////////////////////////////
    // Compare and report
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task close_out;
        $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: model expectation from the inputs held over the last edge
    initial
    begin
        m_pin = '0;
        msk = 16'hffff;
        for (i = 0; i < 400; i++)
        begin
            @(posedge mclk_in);
            #1;
            eff = dat;                                          // Alternate data selection
            if (ctl[0]) {eff[3], eff[1]} = pd[1:0];
            if (ctl[1] && ctl[2]) {eff[13], eff[9]} = {pd[3], pd[2]};
            if (ctl[1] && !ctl[2]) eff[8] = pd[2];
            if (ctl[3]) eff[10] = pd[4];
            if (ctl[3] && ctl[4]) eff[11] = pd[5];
            if (ctl[5]) eff[12] = ctl[6] ? pd[7] : pd[6];
            if (ctl[7]) eff[15] = 1'b1;
            e_oe = '1;
            e_out = '0;
            for (b = 0; b < 16; b++)
                if (rst_n_in && dir[b] && b != P3_MISSING)
                    {e_out[b], e_oe[b]} = od[b] ? {1'b0, eff[b]} : {eff[b], 1'b0};
            e_rd = rst_n_in ? m_pin & P3_VALID : '0;
            e_p5 = rst_n_in ? p5 : '0;
            e_per = rst_n_in ? {m_pin[11], m_pin[13], ctl[2] ? m_pin[8] : m_pin[9],
                m_pin[7:4], m_pin[2], p5} : '0;
            ck_drv = rst_n_in && ctl[7] && dir[15];             // Clock drives bit 15
            ck_od = od[15];                                     // Driver type of the clock
            chk(oe_n, e_oe);
            chk(pin_o, e_out);
            chk(rd & msk, e_rd & msk);
            chk(p5_rd, e_p5);
            chk(per[5:0], e_per[5:0]);
            chk(per[10:6], e_per[10:6]);
            chk(per[13:11], e_per[13:11]);
            msk = (rst_n_in && ctl[7] && dir[15]) ? 16'h7fff : 16'hffff;
            dir = 16'($random(seed));
            od = 16'($random(seed));
            dat = 16'($random(seed));
            ext = 16'($random(seed));
            // Pin level during this cycle, sampled at the next edge, with the new board pattern
            m_pin = (e_oe & ext) | (~e_oe & e_out);
            ctl = 9'($random(seed));
            pd = 8'($random(seed));
            p5 = 6'($random(seed));
            rst_n_in = (i >= 5) && (($random(seed) & 31) != 0);
            if (ck_drv)
            begin
                @(negedge mclk_in);
                #1;
                chk(ck_od ? oe_n[15] : pin_o[15], 1'b0);
            end
        end
        close_out;
    end
endmodule

// ---- sim/pp_port_logic_checker.sv ----
// Checker for pin drive, reset state and input sampling of the port logic
`timescale 1ns/1ps
module pp_port_logic_checker
(
    input  wire logic [0:0]   mclk_in,             // CPU clock
    input  wire logic [0:0]   rst_n_in,            // Sync reset, active low
    input  wire logic [15:0]  p3_dir_in,           // Direction, 1 = output
    input  wire logic [15:0]  p3_od_in,            // Open-drain select
    input  wire logic [15:0]  p3_data_in,          // Output latch value
    input  wire logic [15:0]  p3_pin_in,           // Port 3 pin levels
    input  wire logic [15:0]  p3_pin_out,          // Port 3 drive levels
    input  wire logic [15:0]  p3_pin_oe_n_out,     // Low while driving
    input  wire logic [15:10] p5_pin_in,           // Port 5 pin levels
    input  wire logic [15:10] p5_read_out,         // Sampled port 5
    input  wire logic         ssc_master_in,       // Sync serial master mode
    input  wire logic         ssc_rx_out,          // Sync serial receive data
    input  wire logic         capture_trigger_out  // Capture trigger
);
    ////////////////////////////////////////////////////////////////////////////////
    // All checks run on the CPU clock and stand still in reset
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    AST_NO_PIN_14: assert property (p3_pin_oe_n_out[14] && !p3_pin_out[14])
        else $error("Absent bit 14 is driven");
    AST_INPUT_HIZ: assert property ($past(rst_n_in) |->
        &(p3_pin_oe_n_out | $past(p3_dir_in)))
        else $error("Input pin not high impedance");
    AST_RESET_INPUT: assert property ($rose(rst_n_in) |-> p3_pin_oe_n_out == 16'hffff)
        else $error("Pin driving right after reset");
    AST_PUSH_PULL: assert property ($past(rst_n_in) && $past(p3_dir_in[0])
        && !$past(p3_od_in[0]) |-> !p3_pin_oe_n_out[0] && p3_pin_out[0] == $past(p3_data_in[0]))
        else $error("Push/pull bit 0 wrong");
    AST_OPEN_DRAIN: assert property ($past(rst_n_in) && $past(p3_dir_in[0])
        && $past(p3_od_in[0]) |-> !p3_pin_out[0] && p3_pin_oe_n_out[0] == $past(p3_data_in[0]))
        else $error("Open-drain bit 0 wrong");
    AST_PORT5_READ: assert property ($past(rst_n_in) |-> p5_read_out == $past(p5_pin_in))
        else $error("Port 5 read wrong");
    AST_CAPTURE: assert property ($past(rst_n_in) |->
        capture_trigger_out == $past(p3_pin_in[2]))
        else $error("Capture trigger wrong");
    AST_SSC_RX: assert property ($past(rst_n_in) |-> ssc_rx_out ==
        (ssc_master_in ? $past(p3_pin_in[8]) : $past(p3_pin_in[9])))
        else $error("Serial receive routing wrong");
endmodule
bind pp_port_logic pp_port_logic_checker u_chk (.mclk_in, .rst_n_in, .p3_dir_in, .p3_od_in,
    .p3_data_in, .p3_pin_in, .p3_pin_out, .p3_pin_oe_n_out, .p5_pin_in, .p5_read_out,
    .ssc_master_in, .ssc_rx_out, .capture_trigger_out);
